// ==== src/aklfb_key_builder.sv ====
// Functional notes
// - ingress port mask in slots 10-13, top flags
// - egress phase uses egress mask, same layout
// - dest mac, target hw addr when selected
// - source mac, sender hw addr when selected
// - outer tag, port defaults when untagged
// - inner tag, port defaults when untagged
// - source ip low words, arp sender address
// - dest ip low words, arp target address
// - tos and protocol, arp opcode, else bytes
// - l4 source port by l4 type
// - l4 dest port, arp sender hw part
// - header flags hop class, frag, ipv6 ext
// - tcp information field layout
// - selector valid with ipv4 and l2 errors
// - port extension replaces selectors three to five, except at egress
// - ipv6 dest pieces, arp target high word
// - packet info port, mac type, hit flags
// - llc sap, gre, mpls, gtp substitutes
// - forwarding vid with routing flags ingress
// - tunnel termination app type and index
// - metadata with loopback count
// - misc bit 0 selects arp addresses
`timescale 1ns/1ps
`include "aklfb_map.svh"
module aklfb_key_builder
  import aklfb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic pkt_valid_i,
  input wire aklfb_phase_type phase_i,
  input wire aklfb_l3_type l3_type_i,
  input wire aklfb_l4_type l4_type_i,
  input wire logic is_non_ip_eth_i,
  input wire logic [56:0] port_mask_i,
  input wire logic loopback_i,
  input wire logic [5:0] vrf_id_i,
  input wire logic [47:0] frame_da_i,
  input wire logic [47:0] frame_sa_i,
  input wire logic [47:0] arp_tha_i,
  input wire logic [47:0] arp_sha_i,
  input wire logic [31:0] arp_spa_i,
  input wire logic [31:0] arp_tpa_i,
  input wire logic [15:0] arp_opcode_i,
  input wire logic outer_tag_present_i,
  input wire logic [15:0] outer_tag_i,
  input wire logic inner_tag_present_i,
  input wire logic [15:0] inner_tag_i,
  input wire logic [2:0] port_pri_i,
  input wire logic [11:0] port_ovid_i,
  input wire logic [11:0] port_ivid_i,
  input wire logic [127:0] sip_i,
  input wire logic [127:0] dip_i,
  input wire logic [7:0] tos_i,
  input wire logic [7:0] proto_i,
  input wire logic [15:0] after_type_i,
  input wire logic [31:0] l4_hdr_i,
  input wire logic [7:0] hop_limit_i,
  input wire logic ip_frag_i,
  input wire logic [2:0] ip_flags_i,
  input wire logic [9:0] ext_hdr_flags_i,
  input wire logic extra_tagged_i,
  input wire logic [19:0] flow_label_i,
  input wire logic tcp_seq_nz_i,
  input wire logic [7:0] tcp_flags_i,
  input wire logic ipv4_hdr_err_i,
  input wire logic l2_err_i,
  input wire logic [13:0] sel_valid_i,
  input wire logic [15:0] user_sel_i [14],
  input wire logic [15:0] pext_sel_i [3],
  input wire logic [5:0] src_port_i,
  input wire logic [1:0] dmac_type_i,
  input wire logic [7:0] hit_flags_i,
  input wire logic [15:0] llc_sap_i,
  input wire logic is_gre_i,
  input wire logic is_mpls_i,
  input wire logic is_gtp_i,
  input wire logic [15:0] encap_word_i,
  input wire logic [11:0] fwd_vid_i,
  input wire logic too_deep_i,
  input wire logic uc_route_i,
  input wire logic mc_route_i,
  input wire logic [2:0] tun_app_i,
  input wire logic tun_term_i,
  input wire logic [9:0] tun_index_i,
  input wire logic [3:0] loop_count_i,
  input wire logic [11:0] metadata_i,
  output logic key_valid_o,
  output logic [15:0] ingress_port_mask_slice0_o [4],
  output logic [15:0] dest_mac_o [3],
  output logic [15:0] src_mac_o [3],
  output logic [15:0] outer_tag_field_o,
  output logic [15:0] inner_tag_field_o,
  output logic [15:0] src_ip_o [2],
  output logic [15:0] dst_ip_o [2],
  output logic [15:0] tos_protocol_field_o,
  output logic [15:0] l4_source_port_field_o,
  output logic [15:0] l4_dest_port_field_o,
  output logic [15:0] header_flags_field_o,
  output logic [15:0] tcp_information_field_o,
  output logic [15:0] selector_valid_o,
  output logic [15:0] user_selector_o [14],
  output logic [15:0] ipv6_dst_piece_o [6],
  output logic [15:0] packet_information_field_o,
  output logic [15:0] llc_sap_field_o,
  output logic [15:0] forwarding_vid_field_o,
  output logic [15:0] tunnel_termination_field_o,
  output logic [15:0] phase_metadata_field_o
);

  typedef struct packed {
    aklfb_bus_type bus;
    logic [1:0] misc;
    logic ack;
    logic err;
    logic [31:0] rdat;
    logic [31:0] key_count;
    logic kv;
    logic [3:0][15:0] pm;
    logic [2:0][15:0] dm;
    logic [2:0][15:0] sm;
    logic [15:0] ot;
    logic [15:0] it;
    logic [1:0][15:0] sip;
    logic [1:0][15:0] dip;
    logic [15:0] tp;
    logic [15:0] l4s;
    logic [15:0] l4d;
    logic [15:0] hf;
    logic [15:0] ti;
    logic [15:0] sv;
    logic [13:0][15:0] us;
    logic [5:0][15:0] d6;
    logic [15:0] pi;
    logic [15:0] llc;
    logic [15:0] fv;
    logic [15:0] tt;
    logic [15:0] md;
  } aklfb_state_type;

  aklfb_state_type st_r;
  aklfb_state_type st_nxt;
  logic is_arp;
  logic is_ip;
  logic use_arp_hw;
  logic [47:0] da_sel;
  logic [47:0] sa_sel;
  logic [1:0] hop_cls;

  always_comb
  begin
    is_arp = (l3_type_i == AKLFB_L3_ARP);
    is_ip = (l3_type_i == AKLFB_L3_IPV4) || (l3_type_i == AKLFB_L3_IPV6);
    use_arp_hw = is_arp && st_r.misc[`AKLFB_ARP_SEL_BIT];
    da_sel = use_arp_hw ? arp_tha_i : frame_da_i;
    sa_sel = use_arp_hw ? arp_sha_i : frame_sa_i;
    if (hop_limit_i == 8'h00)
      hop_cls = `AKLFB_HOP_ZERO;
    else if (hop_limit_i == 8'h01)
      hop_cls = `AKLFB_HOP_ONE;
    else if (hop_limit_i == 8'hff)
      hop_cls = `AKLFB_HOP_MAX;
    else
      hop_cls = `AKLFB_HOP_MID;
  end

  always_comb
  begin
    st_nxt = st_r;
    // bus slave: single-cycle ack, dropped the cycle after
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    unique case (st_r.bus)
      AKLFB_BUS_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          st_nxt.bus = AKLFB_BUS_ACK;
          st_nxt.rdat = 32'h0000_0000;
          if (wb_adr_i == `AKLFB_MISC_OFS)
          begin
            st_nxt.ack = 1'b1;
            st_nxt.rdat = {30'h0000_0000, st_r.misc};
            if (wb_we_i && wb_sel_i[0])
              st_nxt.misc = wb_dat_i[1:0];
          end
          else if (wb_adr_i == `AKLFB_STATUS_OFS)
          begin
            st_nxt.ack = 1'b1;
            st_nxt.rdat = st_r.key_count;
          end
          else
            st_nxt.err = 1'b1;
        end
      end
      AKLFB_BUS_ACK:
        st_nxt.bus = AKLFB_BUS_DONE;
      AKLFB_BUS_DONE:
        if (!(wb_cyc_i && wb_stb_i))
          st_nxt.bus = AKLFB_BUS_IDLE;
      default:
        st_nxt.bus = AKLFB_BUS_IDLE;
    endcase

    st_nxt.kv = pkt_valid_i;
    if (pkt_valid_i)
      st_nxt.key_count = st_r.key_count + 32'h0000_0001;

    // port mask, ingress or egress by phase; same layout both ways
    st_nxt.pm[0] = port_mask_i[15:0];
    st_nxt.pm[1] = port_mask_i[31:16];
    st_nxt.pm[2] = port_mask_i[47:32];
    st_nxt.pm[3] = {loopback_i, vrf_id_i, port_mask_i[56:48]};

    for (int i = 0; i < 3; i++)
    begin
      st_nxt.dm[i] = da_sel[16*i +: 16];
      st_nxt.sm[i] = sa_sel[16*i +: 16];
    end

    st_nxt.ot = outer_tag_present_i ? outer_tag_i : {port_pri_i, 1'b0, port_ovid_i};
    st_nxt.it = inner_tag_present_i ? inner_tag_i : {port_pri_i, 1'b0, port_ivid_i};

    // anything that does not fit the frame type reads as zero
    st_nxt.sip = '0;
    st_nxt.dip = '0;
    st_nxt.tp = 16'h0000;
    st_nxt.l4s = 16'h0000;
    st_nxt.l4d = 16'h0000;
    st_nxt.hf = 16'h0000;
    st_nxt.ti = 16'h0000;
    st_nxt.d6 = '0;
    st_nxt.llc = llc_sap_i;
    if (is_ip)
    begin
      st_nxt.sip = {sip_i[31:16], sip_i[15:0]};
      st_nxt.dip = {dip_i[31:16], dip_i[15:0]};
      st_nxt.tp = {tos_i, proto_i};
      st_nxt.l4d = l4_hdr_i[15:0];
      unique case (l4_type_i)
        AKLFB_L4_ICMP, AKLFB_L4_IGMP, AKLFB_L4_MLD:
          st_nxt.l4s = {l4_hdr_i[31:24], l4_hdr_i[23:16]};
        default:
          st_nxt.l4s = l4_hdr_i[31:16];
      endcase
      st_nxt.hf = {ext_hdr_flags_i, ip_flags_i, ip_frag_i, hop_cls};
      st_nxt.ti = {2'h0, extra_tagged_i, flow_label_i[19:16], tcp_seq_nz_i,
                   tcp_flags_i[7:6], tcp_flags_i[5:0]};
      if (l3_type_i == AKLFB_L3_IPV6)
        for (int i = 0; i < 6; i++)
          st_nxt.d6[i] = dip_i[32 + 16*i +: 16];
    end
    else if (is_arp)
    begin
      st_nxt.sip = {arp_spa_i[31:16], arp_spa_i[15:0]};
      st_nxt.dip = {arp_tpa_i[31:16], arp_tpa_i[15:0]};
      st_nxt.tp = arp_opcode_i;
      st_nxt.l4s = arp_sha_i[15:0];
      st_nxt.l4d = arp_sha_i[31:16];
      st_nxt.hf = arp_tha_i[15:0];
      st_nxt.ti = arp_sha_i[47:32];
      st_nxt.d6[0] = arp_tha_i[47:32];
    end
    else if (is_non_ip_eth_i)
      st_nxt.tp = after_type_i;

    if (is_gre_i || is_mpls_i || is_gtp_i)
      st_nxt.llc = encap_word_i;

    st_nxt.sv = {ipv4_hdr_err_i, l2_err_i, sel_valid_i};

    for (int i = 0; i < 14; i++)
      st_nxt.us[i] = (phase_i == AKLFB_PH_EGRESS) ? 16'h0000 : user_sel_i[i];
    if (st_r.misc[`AKLFB_PEXT_EN_BIT] && phase_i != AKLFB_PH_EGRESS)
      for (int i = 0; i < 3; i++)
        st_nxt.us[3 + i] = pext_sel_i[i];
    // ipv6 source claims the shared slots; only meaning left at egress
    if (l3_type_i == AKLFB_L3_IPV6)
      for (int i = 0; i < 6; i++)
        st_nxt.us[6 + i] = sip_i[32 + 16*i +: 16];
    else if (phase_i == AKLFB_PH_EGRESS)
      for (int i = 0; i < 6; i++)
        st_nxt.us[6 + i] = 16'h0000;

    st_nxt.pi = {src_port_i, dmac_type_i, hit_flags_i};
    st_nxt.fv = {1'b0, (phase_i == AKLFB_PH_INGRESS) ? uc_route_i : 1'b0,
                 (phase_i == AKLFB_PH_INGRESS) ? mc_route_i : 1'b0,
                 too_deep_i, fwd_vid_i};
    st_nxt.tt = {2'h0, tun_app_i, tun_term_i, tun_index_i};
    st_nxt.md = {loop_count_i, metadata_i};

    if (rst_i)
    begin
      st_nxt = '0;
      st_nxt.bus = AKLFB_BUS_IDLE;
      st_nxt.misc = `AKLFB_MISC_RST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_r <= st_nxt;
  end

  always_comb
  begin
    wb_ack_o = st_r.ack;
    wb_err_o = st_r.err;
    wb_dat_o = st_r.rdat;
    key_valid_o = st_r.kv;
    outer_tag_field_o = st_r.ot;
    inner_tag_field_o = st_r.it;
    tos_protocol_field_o = st_r.tp;
    l4_source_port_field_o = st_r.l4s;
    l4_dest_port_field_o = st_r.l4d;
    header_flags_field_o = st_r.hf;
    tcp_information_field_o = st_r.ti;
    selector_valid_o = st_r.sv;
    packet_information_field_o = st_r.pi;
    llc_sap_field_o = st_r.llc;
    forwarding_vid_field_o = st_r.fv;
    tunnel_termination_field_o = st_r.tt;
    phase_metadata_field_o = st_r.md;
    for (int i = 0; i < 4; i++)
      ingress_port_mask_slice0_o[i] = st_r.pm[i];
    for (int i = 0; i < 3; i++)
    begin
      dest_mac_o[i] = st_r.dm[i];
      src_mac_o[i] = st_r.sm[i];
    end
    for (int i = 0; i < 2; i++)
    begin
      src_ip_o[i] = st_r.sip[i];
      dst_ip_o[i] = st_r.dip[i];
    end
    for (int i = 0; i < 14; i++)
      user_selector_o[i] = st_r.us[i];
    for (int i = 0; i < 6; i++)
      ipv6_dst_piece_o[i] = st_r.d6[i];
  end

endmodule // aklfb_key_builder

// ==== src/aklfb_map.svh ====
`ifndef AKLFB_MAP_SVH
`define AKLFB_MAP_SVH
// register byte offsets
`define AKLFB_MISC_OFS 4'h0
`define AKLFB_STATUS_OFS 4'h4
// control field positions
`define AKLFB_ARP_SEL_BIT 0
`define AKLFB_PEXT_EN_BIT 1
`define AKLFB_MISC_RST 2'h0
// hop limit classes
`define AKLFB_HOP_ZERO 2'h0
`define AKLFB_HOP_ONE 2'h1
`define AKLFB_HOP_MID 2'h2
`define AKLFB_HOP_MAX 2'h3
// destination mac types
`define AKLFB_DMT_UC 2'h0
`define AKLFB_DMT_BC 2'h1
`define AKLFB_DMT_MC 2'h3
`endif

// ==== src/aklfb_pkg.sv ====
package aklfb_pkg;
  typedef enum logic [1:0] {
    AKLFB_L3_ARP = 2'h0,
    AKLFB_L3_L2 = 2'h1,
    AKLFB_L3_IPV4 = 2'h2,
    AKLFB_L3_IPV6 = 2'h3
  } aklfb_l3_type;
  typedef enum logic [2:0] {
    AKLFB_L4_UDP = 3'h0,
    AKLFB_L4_TCP = 3'h1,
    AKLFB_L4_ICMP = 3'h2,
    AKLFB_L4_IGMP = 3'h3,
    AKLFB_L4_MLD = 3'h4,
    AKLFB_L4_SCTP = 3'h5,
    AKLFB_L4_UNK = 3'h6
  } aklfb_l4_type;
  typedef enum logic [1:0] {
    AKLFB_PH_VLAN = 2'h0,
    AKLFB_PH_INGRESS = 2'h1,
    AKLFB_PH_EGRESS = 2'h2
  } aklfb_phase_type;
  typedef enum logic [2:0] {
    AKLFB_BUS_IDLE = 3'b001,
    AKLFB_BUS_ACK = 3'b010,
    AKLFB_BUS_DONE = 3'b100
  } aklfb_bus_type;
endpackage

// ==== test/aklfb_parser_model.sv ====
`timescale 1ns/1ps
module aklfb_parser_model (
  input wire logic clk_i,
  input wire logic [63:0] rnd_i,
  output logic [47:0] da_o,
  output logic [47:0] sa_o,
  output logic [47:0] tha_o,
  output logic [47:0] sha_o
);
  // one pipeline stage: addresses trail the control fields by a cycle, as in the parser
  logic [63:0] word_r = '0;
  always @(posedge clk_i)
    word_r <= rnd_i;
  assign da_o = word_r[47:0];
  assign sa_o = word_r[63:16];
  assign tha_o = ~word_r[47:0];
  assign sha_o = {word_r[15:0], word_r[63:32]};
endmodule // aklfb_parser_model

// ==== test/aklfb_kb_asserts.sv ====
`timescale 1ns/1ps
module aklfb_kb_asserts
  import aklfb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic pkt_valid_i,
  input wire logic key_valid_o,
  input wire aklfb_phase_type phase_i,
  input wire logic uc_route_i,
  input wire logic mc_route_i,
  input wire logic [15:0] forwarding_vid_field_o,
  input wire logic [3:0] loop_count_i,
  input wire logic [11:0] metadata_i,
  input wire logic [15:0] phase_metadata_field_o
);
  // hold checks off one more edge: the edge that releases reset still shows reset state
  logic rst_d_r;
  always_ff @(posedge clk_i)
    rst_d_r <= rst_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i || rst_d_r);
  map_ack_a: assert property ($rose(wb_stb_i) && wb_adr_i inside {4'h0, 4'h4}
    |=> wb_ack_o && !wb_err_o) else $error("mapped access not acked");
  unmap_err_a: assert property ($rose(wb_stb_i) && !(wb_adr_i inside {4'h0, 4'h4})
    |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
  idle_quiet_a: assert property (!wb_stb_i |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  key_delay_a: assert property (1'b1 |=> key_valid_o == $past(pkt_valid_i))
    else $error("key valid not one cycle late");
  meta_field_a: assert property (1'b1 |=>
    phase_metadata_field_o == $past({loop_count_i, metadata_i})) else $error("metadata wrong");
  route_flags_a: assert property (phase_i == AKLFB_PH_INGRESS |=>
    forwarding_vid_field_o[14:13] == $past({uc_route_i, mc_route_i}))
    else $error("routing flags wrong");
  route_quiet_a: assert property (phase_i != AKLFB_PH_INGRESS |=>
    forwarding_vid_field_o[14:13] == 2'h0) else $error("routing flags outside ingress");
endmodule // aklfb_kb_asserts
bind aklfb_key_builder aklfb_kb_asserts chk_u (.*);

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb
  import aklfb_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, key_valid_o;
  logic [3:0] wb_adr_i, wb_sel_i, loop_count_i;
  logic [31:0] wb_dat_i, wb_dat_o, arp_spa_i, arp_tpa_i, l4_hdr_i;
  aklfb_phase_type phase_i;
  aklfb_l3_type l3_type_i;
  aklfb_l4_type l4_type_i;
  logic pkt_valid_i, is_non_ip_eth_i, loopback_i, outer_tag_present_i, inner_tag_present_i;
  logic ip_frag_i;
  logic extra_tagged_i, tcp_seq_nz_i, ipv4_hdr_err_i, l2_err_i, is_gre_i, is_mpls_i, is_gtp_i;
  logic too_deep_i, uc_route_i, mc_route_i, tun_term_i;
  logic [56:0] port_mask_i;
  logic [5:0] vrf_id_i, src_port_i;
  logic [47:0] frame_da_i, frame_sa_i, arp_tha_i, arp_sha_i;
  logic [15:0] arp_opcode_i, outer_tag_i, inner_tag_i, after_type_i, llc_sap_i, encap_word_i;
  logic [2:0] port_pri_i, ip_flags_i, tun_app_i;
  logic [11:0] port_ovid_i, port_ivid_i, fwd_vid_i, metadata_i;
  logic [127:0] sip_i, dip_i;
  logic [7:0] tos_i, proto_i, hop_limit_i, tcp_flags_i, hit_flags_i;
  logic [9:0] ext_hdr_flags_i, tun_index_i;
  logic [19:0] flow_label_i;
  logic [13:0] sel_valid_i;
  logic [1:0] dmac_type_i, mode;
  logic [15:0] user_sel_i [14], pext_sel_i [3], ingress_port_mask_slice0_o [4], dest_mac_o [3];
  logic [15:0] src_mac_o [3], src_ip_o [2], dst_ip_o [2], user_selector_o [14];
  logic [15:0] ipv6_dst_piece_o [6], outer_tag_field_o, inner_tag_field_o, tos_protocol_field_o;
  logic [15:0] l4_source_port_field_o, l4_dest_port_field_o, header_flags_field_o;
  logic [15:0] tcp_information_field_o, selector_valid_o, packet_information_field_o;
  logic [15:0] llc_sap_field_o, forwarding_vid_field_o, tunnel_termination_field_o;
  logic [15:0] phase_metadata_field_o;
  logic [31:0] seed = 32'h0000_0027;
  logic [31:0] q;
  logic [63:0] pr = '0;
  logic e;
  int failures = 0;
  int checked = 0;
  aklfb_key_builder dut_u (.*);
  aklfb_parser_model pm_u (.clk_i, .rnd_i(pr), .da_o(frame_da_i), .sa_o(frame_sa_i),
    .tha_o(arp_tha_i), .sha_o(arp_sha_i));
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] hop_cls(input logic [7:0] h);
    return h == 8'h00 ? 2'h0 : h == 8'h01 ? 2'h1 : h == 8'hff ? 2'h3 : 2'h2;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic summarize();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic drive();
    logic [1279:0] rv;
    for (int k = 0; k < 40; k++)
      rv[k*32+:32] = xs();
    {pkt_valid_i, is_non_ip_eth_i, port_mask_i, loopback_i, vrf_id_i, arp_spa_i, arp_tpa_i,
      arp_opcode_i, outer_tag_present_i, outer_tag_i, inner_tag_present_i, inner_tag_i,
      port_pri_i, port_ovid_i, port_ivid_i, sip_i, dip_i, tos_i, proto_i, after_type_i, l4_hdr_i,
      ip_frag_i, ip_flags_i,
      ext_hdr_flags_i, extra_tagged_i, flow_label_i, tcp_seq_nz_i, tcp_flags_i, ipv4_hdr_err_i,
      l2_err_i, sel_valid_i, src_port_i, dmac_type_i, hit_flags_i, llc_sap_i, is_gre_i,
      is_mpls_i, is_gtp_i, encap_word_i, fwd_vid_i, too_deep_i, uc_route_i, mc_route_i,
      tun_app_i, tun_term_i, tun_index_i, loop_count_i, metadata_i} <= rv[682:0];
    for (int k = 0; k < 14; k++)
      user_sel_i[k] <= rv[700+16*k+:16];
    for (int k = 0; k < 3; k++)
      pext_sel_i[k] <= rv[940+16*k+:16];
    phase_i <= aklfb_phase_type'(rv[990] ? 2'h2 : {1'b0, rv[991]});
    l3_type_i <= aklfb_l3_type'(rv[993:992]);
    l4_type_i <= aklfb_l4_type'(rv[996:994] == 3'h7 ? 3'h6 : rv[996:994]);
    // half the hop limits sit on the class edges 0, 1, 254, 255
    hop_limit_i <= rv[997] ? rv[1007:1000] : {{7{rv[998]}}, rv[998] ^ rv[999]};
    pr <= rv[1279:1216];
  endtask
  task automatic pkt();
    logic a;
    logic ip;
    @(posedge clk_i);
    drive();
    // two edges: the parser model needs one to pass its addresses on
    repeat (2) @(posedge clk_i);
    #1;
    a = l3_type_i == AKLFB_L3_ARP;
    ip = l3_type_i[1];
    chk(ingress_port_mask_slice0_o[3], {loopback_i, vrf_id_i, port_mask_i[56:48]});
    chk(ingress_port_mask_slice0_o[0], port_mask_i[15:0]);
    chk(dest_mac_o[0], a && mode[0] ? arp_tha_i[15:0] : frame_da_i[15:0]);
    chk(src_mac_o[2], a && mode[0] ? arp_sha_i[47:32] : frame_sa_i[47:32]);
    chk(outer_tag_field_o, outer_tag_present_i ? outer_tag_i :
      {port_pri_i, 1'b0, port_ovid_i});
    chk(inner_tag_field_o, inner_tag_present_i ? inner_tag_i :
      {port_pri_i, 1'b0, port_ivid_i});
    chk(src_ip_o[0], a ? arp_spa_i[15:0] : ip ? sip_i[15:0] : 16'h0000);
    chk(dst_ip_o[1], a ? arp_tpa_i[31:16] : ip ? dip_i[31:16] : 16'h0000);
    chk(tos_protocol_field_o, ip ? {tos_i, proto_i} : a ? arp_opcode_i :
      is_non_ip_eth_i ? after_type_i : 16'h0000);
    chk(l4_source_port_field_o, a ? arp_sha_i[15:0] : ip ? l4_hdr_i[31:16] : 16'h0000);
    chk(l4_dest_port_field_o, a ? arp_sha_i[31:16] : ip ? l4_hdr_i[15:0] : 16'h0000);
    if (ip)
      chk(header_flags_field_o[5:0], {ip_flags_i, ip_frag_i, hop_cls(hop_limit_i)});
    else
      chk(header_flags_field_o, a ? arp_tha_i[15:0] : 16'h0000);
    if (phase_i != AKLFB_PH_EGRESS)
      chk(user_selector_o[3], mode[1] ? pext_sel_i[0] : user_sel_i[3]);
    else
      chk(user_selector_o[3], 16'h0000);
    chk(ipv6_dst_piece_o[0], l3_type_i == AKLFB_L3_IPV6 ? dip_i[47:32] :
      a ? arp_tha_i[47:32] : 16'h0000);
    chk(packet_information_field_o, {src_port_i, dmac_type_i, hit_flags_i});
    chk(tunnel_termination_field_o[13:0], {tun_app_i, tun_term_i, tun_index_i});
    chk(tcp_information_field_o, ip ? {2'h0, extra_tagged_i, flow_label_i[19:16],
      tcp_seq_nz_i, tcp_flags_i} : a ? arp_sha_i[47:32] : 16'h0000);
    chk(selector_valid_o, {ipv4_hdr_err_i, l2_err_i, sel_valid_i});
    chk(user_selector_o[6], l3_type_i == AKLFB_L3_IPV6 ? sip_i[47:32] :
      phase_i == AKLFB_PH_EGRESS ? 16'h0000 : user_sel_i[6]);
    chk(llc_sap_field_o, is_gre_i || is_mpls_i || is_gtp_i ?
      encap_word_i : llc_sap_i);
    chk(forwarding_vid_field_o[12:0], {too_deep_i, fwd_vid_i});
  endtask
  initial
  begin
    {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    mode = 2'h0;
    drive();
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(4'h0, 1'b0, 32'h0000_0000);
    chk(q[15:0], 16'h0000);
    wb(4'h8, 1'b0, 32'h0000_0000);
    chk({15'h0000, e}, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_i);
      mode = 2'(m);
      wb(4'h0, 1'b1, {30'h0000_0000, mode});
      wb(4'h0, 1'b0, 32'h0000_0000);
      chk(q[15:0], {14'h0000, mode});
      repeat (60) pkt();
      $display("test with control %0d done", mode);
    end
    summarize();
  end
  initial
  begin
    #100_000;
    failures++;
    summarize();
  end
endmodule // tb
